// ===== core/sdg_spi_core.sv
// SPI engine with status flags, data buffers and inter-byte gap
// How it works
// - Phase 0: gap codes 00..11 give 0.5, 1.0, 1.5, 2.0 clock periods.
// - Phase 1: gap codes 00..11 give 1.0, 1.5, 2.0, 2.5 clock periods.
// - Done flag, status bit 7, sets at byte end; stays until cleared.
// - Data register writes are ignored while the done flag is set.
// - Done flag raises the interrupt when its mask bit and both enables are set.
// - Collision flag, status bit 6, sets on a write collision; sticky.
// - Overrun flag, status bit 5, sets on overrun, sticky, raises interrupt.
// - Master with fault detection: select low sets fault flag, bit 4.
// - Fault disable bit 3: 0 select is fault input, 1 follows output enable.
// - Status bit 2 reads 1 while transmit buffer is full, else 0.
// - Data writes load the shifter path; reads return the receive buffer.
// - In master mode a data write starts a full-duplex byte transfer.
// - Select output drives low per transfer, high idle; else left as I/O.
// - Phase 0 samples on first clock edge, phase 1 on second.
// - Master bit 0 selects slave, 1 selects master.
module sdg_spi_core (
    input  logic                       clk_sys_i,
    input  logic                       arst_n_i,
    input  logic [sdg_pkg::ADDR_W-1:0] reg_addr_i,
    input  logic [sdg_pkg::DATA_W-1:0] reg_wdata_i,
    input  logic                       reg_wr_i,
    input  logic                       reg_rd_i,
    output logic [sdg_pkg::DATA_W-1:0] reg_rdata_o,
    output logic                       irq_o,
    input  logic                       sclk_i,
    output logic                       sclk_o,
    output logic                       sclk_oe_o,
    input  logic                       mosi_i,
    output logic                       mosi_o,
    output logic                       mosi_oe_o,
    input  logic                       miso_i,
    output logic                       miso_o,
    output logic                       miso_oe_o,
    input  logic                       ss_n_i,
    output logic                       ss_n_o,
    output logic                       ss_n_oe_o
);
    import sdg_pkg::*;

    logic [SYNC_W-1:0] pin_s;
    logic              sclk_s;
    logic              mosi_s;
    logic              miso_s;
    logic              ss_n_s;

    sdg_sync sdg_sync_inst (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .d_i       ({sclk_i, mosi_i, miso_i, ss_n_i}),
        .q_o       (pin_s)
    );
    assign {sclk_s, mosi_s, miso_s, ss_n_s} = pin_s;

    // Register state
    logic [DATA_W-1:0] ctrl_ff, nxt_ctrl;
    logic [1:0]        gap_ff, nxt_gap;
    logic [3:0]        mask_ff, nxt_mask;
    logic [1:0]        ien_ff, nxt_ien;
    logic              done_ff, nxt_done;
    logic              write_collision_flag_ff, nxt_write_collision_flag;
    logic              ovf_ff, nxt_ovf;
    logic              fault_ff, nxt_fault;
    logic              dis_ff, nxt_dis;
    logic              txf_ff, nxt_txf;
    logic [DATA_W-1:0] txb_ff, nxt_txb;
    logic [DATA_W-1:0] rxb_ff, nxt_rxb;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;

    // Engine state
    sdg_state_t        state_ff, nxt_state;
    logic [DIV_W-1:0]  div_ff, nxt_div;
    logic [GAP_W-1:0]  half_ff, nxt_half;
    logic [IDX_W-1:0]  idx_ff, nxt_idx;
    logic [DATA_W-1:0] sh_ff, nxt_sh;
    logic              out_ff, nxt_out;
    logic              sclk_ff, nxt_sclk;
    logic              sclkd_ff;
    logic              ssn_ff, nxt_ssn;

    logic             master, en, clock_phase_select, cpol, lsb;
    logic             m_on, sel, fault_mode, ss_drive;
    logic             m_ev, s_ev, ev, samp, shout, byte_end, load, in_bit;
    logic             wr_data, wr_ok, take;
    logic [GAP_W-1:0] gap_len;
    logic [3:0]       flags;

    assign master     = ctrl_ff[CT_MASTER];
    assign en         = ctrl_ff[CT_EN];
    assign clock_phase_select = ctrl_ff[CT_PHASE];
    assign cpol       = ctrl_ff[CT_CPOL];
    assign lsb        = ctrl_ff[CT_LSB];
    assign m_on       = en && master;
    assign sel        = en && !master && !ss_n_s;
    assign fault_mode = m_on && !dis_ff;
    assign ss_drive   = m_on && dis_ff && ctrl_ff[CT_SEL_OUT];
    assign gap_len    = {1'b0, gap_ff} + {2'b00, clock_phase_select};
    assign s_ev       = sel && (sclk_s != sclkd_ff);
    assign ev         = m_ev || s_ev;
    assign samp       = ev && (idx_ff[0] == clock_phase_select);
    assign shout      = ev && (idx_ff[0] != clock_phase_select);
    assign byte_end   = ev && (idx_ff == EDGE_LAST);
    assign in_bit     = master ? miso_s : mosi_s;
    assign wr_data    = reg_wr_i && (reg_addr_i == ADR_DATA);

    // Engine: clock divider, gap timer, bit counter and shifter
    always_comb begin
        nxt_state = state_ff;
        nxt_div   = div_ff;
        nxt_half  = half_ff;
        nxt_idx   = idx_ff;
        nxt_sh    = sh_ff;
        nxt_out   = out_ff;
        nxt_sclk  = sclk_ff;
        m_ev      = 1'b0;
        load      = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                nxt_sclk = cpol;
                if (m_on && txf_ff) begin
                    load      = 1'b1;
                    nxt_state = ST_SHIFT;
                    nxt_div   = '0;
                end
            end
            ST_SHIFT: begin
                if (div_ff == HALF_LAST) begin
                    nxt_div  = '0;
                    m_ev     = 1'b1;
                    nxt_sclk = ~sclk_ff;
                    if (idx_ff == EDGE_LAST) begin
                        nxt_half  = '0;
                        nxt_state = (gap_len == '0) ? ST_IDLE : ST_GAP;
                    end
                end else begin
                    nxt_div = div_ff + 1'b1;
                end
            end
            ST_GAP: begin
                // Clock stays parked; sixteen toggles left it at idle level
                if (div_ff == HALF_LAST) begin
                    nxt_div = '0;
                    if (half_ff == gap_len - 1'b1) begin
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_half = half_ff + 1'b1;
                    end
                end else begin
                    nxt_div = div_ff + 1'b1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (!m_on) begin
            nxt_state = ST_IDLE;
            nxt_sclk  = cpol;
        end
        // Slave preloads only before the first edge of a byte
        if (sel && idx_ff == '0 && txf_ff && !s_ev) begin
            load = 1'b1;
        end
        if (load) begin
            nxt_sh  = txb_ff;
            nxt_out = lsb ? txb_ff[0] : txb_ff[DATA_W-1];
            nxt_idx = '0;
        end
        if (ev) begin
            nxt_idx = idx_ff + 1'b1;
        end
        if (samp) begin
            nxt_sh = lsb ? {in_bit, sh_ff[DATA_W-1:1]} : {sh_ff[DATA_W-2:0], in_bit};
        end
        if (shout && !byte_end) begin
            nxt_out = lsb ? sh_ff[0] : sh_ff[DATA_W-1];
        end
        if (!m_on && !sel) begin
            nxt_idx = '0;
        end
        nxt_ssn = (nxt_state == ST_IDLE);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= ST_IDLE;
            div_ff   <= '0;
            half_ff  <= '0;
            idx_ff   <= '0;
            sh_ff    <= RST_BYTE;
            out_ff   <= 1'b0;
            sclk_ff  <= 1'b0;
            sclkd_ff <= 1'b1;
            ssn_ff   <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            div_ff   <= nxt_div;
            half_ff  <= nxt_half;
            idx_ff   <= nxt_idx;
            sh_ff    <= nxt_sh;
            out_ff   <= nxt_out;
            sclk_ff  <= nxt_sclk;
            sclkd_ff <= sclk_s;
            ssn_ff   <= nxt_ssn;
        end
    end

    // Register file, flags and buffers
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_gap   = gap_ff;
        nxt_mask  = mask_ff;
        nxt_ien   = ien_ff;
        nxt_done  = done_ff;
        nxt_write_collision_flag  = write_collision_flag_ff;
        nxt_ovf   = ovf_ff;
        nxt_fault = fault_ff;
        nxt_dis   = dis_ff;
        nxt_txf   = txf_ff;
        nxt_txb   = txb_ff;
        nxt_rxb   = rxb_ff;
        nxt_rdata = '0;
        wr_ok     = wr_data && !done_ff;
        take      = wr_ok && (!txf_ff || load);
        if (load) begin
            nxt_txf = 1'b0;
        end
        if (take) begin
            nxt_txf = 1'b1;
            nxt_txb = reg_wdata_i;
        end
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADR_CTRL: nxt_ctrl = reg_wdata_i;
                ADR_GAP:  nxt_gap  = reg_wdata_i[GAP_HI:GAP_LO];
                ADR_MASK: nxt_mask = reg_wdata_i[SB_DONE:SB_FAULT];
                ADR_IEN:  nxt_ien  = reg_wdata_i[IE_GLB:IE_SPI];
                ADR_STAT: begin
                    nxt_dis = reg_wdata_i[SB_DIS];
                    if (reg_wdata_i[SB_DONE])  nxt_done  = 1'b0;
                    if (reg_wdata_i[SB_WRITE_COLLISION_FLAG])  nxt_write_collision_flag  = 1'b0;
                    if (reg_wdata_i[SB_OVF])   nxt_ovf   = 1'b0;
                    if (reg_wdata_i[SB_FAULT]) nxt_fault = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // Sets come after clears so a same-cycle event wins
        if (byte_end) begin
            nxt_done = 1'b1;
            if (done_ff) begin
                nxt_ovf = 1'b1;
            end else begin
                nxt_rxb = nxt_sh;
            end
        end
        if (wr_ok && !take) begin
            nxt_write_collision_flag = 1'b1;
        end
        if (fault_mode && !ss_n_s) begin
            nxt_fault = 1'b1;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADR_CTRL: nxt_rdata = ctrl_ff;
                ADR_STAT: nxt_rdata = {flags, dis_ff, txf_ff, 2'b00};
                ADR_DATA: nxt_rdata = rxb_ff;
                ADR_GAP:  nxt_rdata = {{(DATA_W-2){1'b0}}, gap_ff};
                ADR_MASK: nxt_rdata = {mask_ff, 4'h0};
                ADR_IEN:  nxt_rdata = {{(DATA_W-2){1'b0}}, ien_ff};
                default:  nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_ff  <= RST_BYTE;
            gap_ff   <= '0;
            mask_ff  <= '0;
            ien_ff   <= '0;
            done_ff  <= 1'b0;
            write_collision_flag_ff  <= 1'b0;
            ovf_ff   <= 1'b0;
            fault_ff <= 1'b0;
            dis_ff   <= 1'b0;
            txf_ff   <= 1'b0;
            txb_ff   <= RST_BYTE;
            rxb_ff   <= RST_BYTE;
            rdata_ff <= RST_BYTE;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            gap_ff   <= nxt_gap;
            mask_ff  <= nxt_mask;
            ien_ff   <= nxt_ien;
            done_ff  <= nxt_done;
            write_collision_flag_ff  <= nxt_write_collision_flag;
            ovf_ff   <= nxt_ovf;
            fault_ff <= nxt_fault;
            dis_ff   <= nxt_dis;
            txf_ff   <= nxt_txf;
            txb_ff   <= nxt_txb;
            rxb_ff   <= nxt_rxb;
            rdata_ff <= nxt_rdata;
        end
    end

    assign flags = {done_ff, write_collision_flag_ff, ovf_ff, fault_ff};
    // Collision can be masked like the others; it is off after reset
    assign irq_o = (ien_ff == IEN_ALL) && |(flags & mask_ff);

    assign reg_rdata_o = rdata_ff;
    assign sclk_o      = sclk_ff;
    assign sclk_oe_o   = m_on;
    assign mosi_o      = out_ff;
    assign mosi_oe_o   = m_on;
    assign miso_o      = out_ff;
    assign miso_oe_o   = sel;
    assign ss_n_o      = ssn_ff;
    assign ss_n_oe_o   = ss_drive;

    // Checks
    logic [GCYC_W-1:0] gap_cyc_ff;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gap_cyc_ff <= '0;
        end else begin
            gap_cyc_ff <= (state_ff == ST_GAP) ? gap_cyc_ff + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    a_gap_length: assert property (
        state_ff == ST_GAP && nxt_state == ST_IDLE && m_on |->
        int'(gap_cyc_ff) + 1 == int'(gap_len) * HALF_CYC)
        else $error("inter-byte gap length wrong");
    a_done_set: assert property (byte_end |=> done_ff)
        else $error("done flag not set at byte end");
    a_write_block: assert property (
        wr_data && done_ff |=> txb_ff == $past(txb_ff) && !$rose(txf_ff) && !write_collision_flag_ff ||
        $past(write_collision_flag_ff))
        else $error("data write taken while done set");
    a_irq_done: assert property (
        byte_end && mask_ff[SB_DONE-SB_FAULT] && ien_ff == IEN_ALL |=> irq_o)
        else $error("no interrupt after byte end");
    a_write_collision_flag_set: assert property (
        wr_data && !done_ff && txf_ff && !load |=> write_collision_flag_ff && txb_ff == $past(txb_ff))
        else $error("collision not flagged");
    a_ovf_set: assert property (
        byte_end && done_ff |=> ovf_ff && rxb_ff == $past(rxb_ff))
        else $error("overrun not flagged or buffer overwritten");
    a_fault_set: assert property (fault_mode && !ss_n_s |=> fault_ff)
        else $error("fault not flagged");
    a_ss_input: assert property (!dis_ff || !master |-> !ss_n_oe_o)
        else $error("select driven while it is an input");
    a_tx_buffer_full_read: assert property (
        reg_rd_i && reg_addr_i == ADR_STAT |=> reg_rdata_o[SB_TXF] == $past(txf_ff))
        else $error("buffer full bit misreported");
    a_data_read: assert property (
        reg_rd_i && reg_addr_i == ADR_DATA |=> reg_rdata_o == $past(rxb_ff))
        else $error("data read not from receive buffer");
    a_master_start: assert property (
        state_ff == ST_IDLE && m_on && txf_ff |=> state_ff == ST_SHIFT && sclk_o == cpol)
        else $error("master did not start");
    a_ss_low: assert property (ss_drive && state_ff == ST_SHIFT |-> !ss_n_o)
        else $error("select not low during transfer");
    a_sample_edge: assert property (
        ev && idx_ff[0] == clock_phase_select && !lsb && !load |=>
        sh_ff[0] == $past(in_bit))
        else $error("data not sampled on selected edge");
    a_slave_quiet: assert property (!master |-> !sclk_oe_o && !mosi_oe_o)
        else $error("slave drives master pins");
    a_sclk_park: assert property (state_ff == ST_GAP |-> sclk_o == cpol)
        else $error("clock not idle during gap");

    c_master_byte: cover property (m_on && byte_end);
    c_slave_byte:  cover property (sel && byte_end);
    c_overrun:     cover property (byte_end && done_ff);
    c_long_gap:    cover property (state_ff == ST_GAP && gap_len == 3'h4);
endmodule

// ===== core/sdg_sync.sv
// Two-stage synchroniser for the serial pin inputs
module sdg_sync (
    input  logic                       clk_sys_i,
    input  logic                       arst_n_i,
    input  logic [sdg_pkg::SYNC_W-1:0] d_i,
    output logic [sdg_pkg::SYNC_W-1:0] q_o
);
    import sdg_pkg::*;

    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;

    genvar g;
    for (g = 0; g < SYNC_W; g++) begin : g_bit
        // Reset high: all pins idle high, so no false select at release
        always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                meta_ff[g] <= SYNC_RST[g];
                sync_ff[g] <= SYNC_RST[g];
            end else begin
                meta_ff[g] <= d_i[g];
                sync_ff[g] <= meta_ff[g];
            end
        end
    end

    assign q_o = sync_ff;
endmodule

// ===== pkg/sdg_pkg.sv
// Constants, register map and types of the SPI status, data and byte gap block
package sdg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    localparam logic [ADDR_W-1:0] ADR_CTRL = 8'hF3;
    localparam logic [ADDR_W-1:0] ADR_STAT = 8'hF4;
    localparam logic [ADDR_W-1:0] ADR_DATA = 8'hF5;
    localparam logic [ADDR_W-1:0] ADR_GAP  = 8'hE3;
    localparam logic [ADDR_W-1:0] ADR_MASK = 8'hE4;
    localparam logic [ADDR_W-1:0] ADR_IEN  = 8'hE5;

    // Control register bits
    localparam int CT_SEL_OUT = 7;
    localparam int CT_EN      = 6;
    localparam int CT_LSB     = 5;
    localparam int CT_MASTER  = 4;
    localparam int CT_CPOL    = 3;
    localparam int CT_PHASE   = 2;

    // Status register bits, also the mask layout
    localparam int SB_DONE  = 7;
    localparam int SB_WRITE_COLLISION_FLAG  = 6;
    localparam int SB_OVF   = 5;
    localparam int SB_FAULT = 4;
    localparam int SB_DIS   = 3;
    localparam int SB_TXF   = 2;

    localparam int GAP_HI = 1;
    localparam int GAP_LO = 0;
    localparam int IE_GLB = 1;
    localparam int IE_SPI = 0;
    localparam logic [1:0] IEN_ALL = 2'h3;

    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

    // Serial clock made in master mode
    localparam int CLK_PERIOD_NS  = 25;
    localparam int SCLK_PERIOD_NS = 1000;
    localparam int HALF_CYC = (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int DIV_W   = 5;
    localparam int IDX_W   = 4;
    localparam int GAP_W   = 3;
    localparam int GCYC_W  = 7;
    localparam int SYNC_W  = 4;
    localparam logic [DIV_W-1:0]  HALF_LAST = DIV_W'(HALF_CYC - 1);
    localparam logic [IDX_W-1:0]  EDGE_LAST = 4'hF;
    localparam logic [SYNC_W-1:0] SYNC_RST  = 4'hF;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_GAP   = 2'b01,
        ST_SHIFT = 2'b10
    } sdg_state_t;
endpackage

// ===== verif/sdg_peer.sv
// Far-side SPI peer: slave when the block masters, master when it is slave
module sdg_peer (
    input  wire logic       sclk_i,
    input  wire logic       mosi_i,
    input  wire logic       miso_i,
    input  wire logic       ss_n_i,
    input  wire logic       clock_phase_select_i,
    input  wire logic [7:0] reply_i,
    output logic            sclk_o,
    output logic            mosi_o,
    output logic            miso_o,
    output logic            ss_n_o,
    output logic [7:0]      got_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    bit lead = 1'b0;
    initial begin
        {sclk_o, mosi_o, miso_o, ss_n_o} = 4'h7;
        got_o = 8'h00;
    end
    // Phase 0 needs the first bit out at select
    always @(negedge ss_n_i) if (!lead) begin
        cnt = 0;
        miso_o = clock_phase_select_i ? ~miso_o : reply_i[7];
    end
    // A released line must not keep its last bit
    always @(posedge ss_n_i) if (!lead) miso_o = ~miso_o;
    always @(sclk_i) if (!ss_n_i && !lead) begin
        cnt++;
        if (cnt[0] != clock_phase_select_i) got_o = {got_o[6:0], mosi_i};
        else miso_o = (cnt < 16) ? reply_i[7 - cnt / 2] : ~miso_o;
    end
    // Master role, phase 0, clock idle low and still between frames
    task automatic master_byte(input logic [7:0] b);
        lead = 1'b1;
        ss_n_o = 1'b0;
        mosi_o = b[7];
        #400;
        for (int n = 1; n <= 16; n++) begin
            sclk_o = ~sclk_o;
            if (n % 2) got_o = {got_o[6:0], miso_i};
            else if (n < 16) mosi_o = b[7 - n / 2];
            #100;
        end
        ss_n_o = 1'b1;
        mosi_o = ~mosi_o;
        lead = 1'b0;
    endtask
    task automatic pull_select(input logic v);
        ss_n_o = v;
    endtask
endmodule

// ===== verif/sdg_spi_core_bench.sv
// Self-checking bench: register port, byte gaps, flags, fault and slave mode
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sdg_spi_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sdg_pkg::*;
    localparam logic [7:0] REPLY = 8'h3C;
    logic       clk_sys_i = 1'b0;
    logic       arst_n_i  = 1'b0;
    logic [7:0] addr      = 8'h00;
    logic [7:0] wdata     = 8'h00;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic       clock_phase_select = 1'b0;
    logic [7:0] rdata, got;
    logic       irq, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
    logic       p_sclk, p_mosi, p_miso, p_ss, sclk_q;
    int         err_total, checks_done, cyc, last_chg, longest;
    wire logic  sclk_w = sclk_oe ? sclk_o : p_sclk;
    wire logic  mosi_w = mosi_oe ? mosi_o : p_mosi;
    wire logic  miso_w = miso_oe ? miso_o : p_miso;
    wire logic  ss_w   = ss_oe ? ss_o : p_ss;

    sdg_spi_core sdg_spi_core_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .irq_o(irq), .sclk_i(sclk_w), .sclk_o(sclk_o),
        .sclk_oe_o(sclk_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe),
        .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe), .ss_n_i(ss_w),
        .ss_n_o(ss_o), .ss_n_oe_o(ss_oe));
    sdg_peer sdg_peer_inst (.sclk_i(sclk_w), .mosi_i(mosi_w), .miso_i(miso_w),
        .ss_n_i(ss_w), .clock_phase_select_i(clock_phase_select), .reply_i(REPLY),
        .sclk_o(p_sclk), .mosi_o(p_mosi), .miso_o(p_miso), .ss_n_o(p_ss), .got_o(got));

    always #12.5 clk_sys_i = ~clk_sys_i;
    // Longest still stretch of the serial clock, sampled off the launching edge
    always @(negedge clk_sys_i) begin
        if (sclk_o !== sclk_q) begin
            if (cyc - last_chg > longest) longest = cyc - last_chg;
            last_chg = cyc;
        end
        sclk_q = sclk_o;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        @(negedge clk_sys_i);
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        @(negedge clk_sys_i);
        `CHK(rdata, e)
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // Bounded, so a stuck transfer ends in mismatches instead of a hang
    // Three high samples, so the one-cycle rise between queued bytes is not the end
    task automatic wait_deselect();
        int h;
        h = 0;
        for (int k = 0; k < 3000 && h < 3; k++) begin
            @(negedge clk_sys_i);
            h = (ss_o === 1'b1) ? h + 1 : 0;
        end
        idle(4);
    endtask

    task automatic t_reset();
        chk_reg(ADR_STAT, RST_BYTE);
        chk_reg(ADR_DATA, RST_BYTE);
        chk_reg(8'h10, RST_BYTE);
        `CHK(irq, 1'b0)
        $display("reset test finished");
    endtask
    task automatic t_single();
        wr_reg(ADR_STAT, 8'h08);
        wr_reg(ADR_CTRL, 8'hD0);
        wr_reg(ADR_MASK, 8'hF0);
        wr_reg(ADR_IEN, IEN_ALL);
        `CHK({ss_oe, ss_o}, 2'h3)
        wr_reg(ADR_DATA, 8'hA5);
        idle(1);
        `CHK(ss_o, 1'b0)
        wait_deselect();
        chk_reg(ADR_DATA, REPLY);
        `CHK(got, 8'hA5)
        `CHK(irq, 1'b1)
        wr_reg(ADR_IEN, 8'h01);
        `CHK(irq, 1'b0)
        wr_reg(ADR_IEN, IEN_ALL);
        wr_reg(ADR_DATA, 8'h5A);
        idle(30);
        `CHK(ss_o, 1'b1)
        chk_reg(ADR_STAT, 8'h88);
        wr_reg(ADR_STAT, 8'h88);
        chk_reg(ADR_STAT, 8'h08);
        `CHK(irq, 1'b0)
        $display("single byte test finished");
    endtask
    task automatic t_gap(input logic ph, input logic [1:0] code);
        logic [7:0] b2;
        b2 = {4'hA, 1'b0, ph, code};
        clock_phase_select = ph;
        // Polarity follows phase, so both idle levels see traffic
        wr_reg(ADR_CTRL, {4'hD, ph, ph, 2'h0});
        wr_reg(ADR_GAP, {6'h00, code});
        last_chg = cyc;
        longest = 0;
        wr_reg(ADR_DATA, 8'h81);
        // Past the first edge, so the lead-in before it is not measured
        idle(30);
        longest = 0;
        wr_reg(ADR_DATA, b2);
        chk_reg(ADR_STAT, 8'h0C);
        wr_reg(ADR_DATA, 8'hFF);
        wait_deselect();
        `CHK(longest, (code + ph + 1) * HALF_CYC + 1)
        `CHK(got, b2)
        chk_reg(ADR_STAT, 8'hE8);
        chk_reg(ADR_DATA, REPLY);
        wr_reg(ADR_STAT, 8'hF8);
        chk_reg(ADR_STAT, 8'h08);
        $display("gap test phase %0d code %0d finished", ph, code);
    endtask
    task automatic t_fault();
        wr_reg(ADR_CTRL, 8'hD0);
        wr_reg(ADR_STAT, 8'h00);
        `CHK(ss_oe, 1'b0)
        sdg_peer_inst.pull_select(1'b0);
        idle(4);
        chk_reg(ADR_STAT, 8'h10);
        `CHK(irq, 1'b1)
        sdg_peer_inst.pull_select(1'b1);
        // Let the synchronised select rise, else the set beats the clear
        idle(3);
        wr_reg(ADR_STAT, 8'h10);
        chk_reg(ADR_STAT, 8'h00);
        wr_reg(ADR_CTRL, 8'h50);
        wr_reg(ADR_STAT, 8'h08);
        sdg_peer_inst.pull_select(1'b0);
        idle(6);
        chk_reg(ADR_STAT, 8'h08);
        `CHK(ss_oe, 1'b0)
        sdg_peer_inst.pull_select(1'b1);
        $display("fault test finished");
    endtask
    task automatic t_slave();
        clock_phase_select = 1'b0;
        wr_reg(ADR_CTRL, 8'h40);
        wr_reg(ADR_DATA, 8'hC3);
        `CHK(sclk_oe, 1'b0)
        `CHK({miso_oe, mosi_oe}, 2'h0)
        sdg_peer_inst.master_byte(8'h96);
        idle(6);
        `CHK(got, 8'hC3)
        chk_reg(ADR_DATA, 8'h96);
        chk_reg(ADR_STAT, 8'h88);
        // Low bit first: both bytes arrive bit-reversed, at the far end and in the receive buffer
        wr_reg(ADR_CTRL, 8'h60);
        wr_reg(ADR_STAT, 8'h88);
        wr_reg(ADR_DATA, 8'h1E);
        sdg_peer_inst.master_byte(8'h96);
        idle(6);
        `CHK(got, 8'h78)
        chk_reg(ADR_DATA, 8'h69);
        $display("slave test finished");
    endtask

    initial begin
        repeat (5) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_single();
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) t_gap(p[0], c[1:0]);
        end
        t_fault();
        t_slave();
        complete_run();
    end
endmodule
